// file: logic/conversion_engine.sv
// Integration timer and charge counter for one conversion at a time.
// Assumes photo_event is a synchronised one-cycle pulse per charge quantum.
`timescale 1ns/100ps
module conversion_engine #(
  parameter int unsigned OSC_DIV = light_sensor_pkg::OSC_DIV
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Control.
  input  wire logic        run,
  input  wire logic [1:0]  resolution,
  input  wire logic        photo_event,
  // Result.
  output logic             done_q,
  output logic [15:0]      result_q
);

  if (OSC_DIV < 2 || OSC_DIV > 65535) begin : g_bad_div
    $error("OSC_DIV out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_INTEG = 2'b10
  } state_t;

  state_t      state_q;
  logic [15:0] presc_q;
  logic [15:0] cycle_q;
  logic [15:0] charge_q;
  logic [15:0] mask_q;
  logic        tick;
  logic        last_cycle;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  assign tick       = (presc_q == 16'(OSC_DIV - 1));
  assign last_cycle = tick && (cycle_q == mask_q);

  always_ff @(posedge clk) begin
    if (reset || state_q == ST_IDLE || tick) begin
      presc_q <= 16'h0000;
    end else begin
      presc_q <= presc_q + 16'h0001;
    end
  end

  // Resolution is latched at the start so a window is never cut short mid-way.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      mask_q  <= 16'hffff;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (run) begin
            state_q <= ST_INTEG;
            mask_q  <= light_sensor_pkg::res_mask(resolution);
          end
        end
        ST_INTEG: begin
          if (!run) begin
            state_q <= ST_IDLE;
          end else if (last_cycle) begin
            mask_q <= light_sensor_pkg::res_mask(resolution);
          end
        end
      endcase
    end
  end

  // Window length is two to the n oscillator cycles.
  always_ff @(posedge clk) begin
    if (reset || state_q == ST_IDLE || last_cycle) begin
      cycle_q <= 16'h0000;
    end else if (tick) begin
      cycle_q <= cycle_q + 16'h0001;
    end
  end

  // Charge count saturates at the top of the selected width.
  always_ff @(posedge clk) begin
    if (reset || state_q == ST_IDLE || last_cycle) begin
      charge_q <= 16'h0000;
    end else if (photo_event && charge_q != mask_q) begin
      charge_q <= charge_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done_q   <= 1'b0;
      result_q <= 16'h0000;
    end else begin
      done_q <= (state_q == ST_INTEG) && run && last_cycle;
      if ((state_q == ST_INTEG) && run && last_cycle) begin
        result_q <= charge_q & mask_q;
      end
    end
  end

endmodule : conversion_engine

// file: logic/light_sensor_adc_readout.sv
// Measurement control, result registers and threshold interrupt of the light sensor.
// Assumes a serial slave in front of it giving byte reads and writes on the same clock.
//
// Behaviour
// - resolution code sets cycles and result width
// - resolution also sets integration window length
// - span code selects one of four ranges
// - result bytes at 02/03, writes ignored
// - result right-aligned from bit zero
// - every finished conversion overwrites both bytes
// - lower limit at 04/05, reset 00
// - upper limit at 06/07, reset FF
// - window lasts two to n oscillator cycles
// - oscillator nominal 655kHz, counts all windows
// - flag after 1/4/8/16 consecutive outside results
// - mode code: off, visible, infrared, reserved
// - mode register transfer end clears flag
`timescale 1ns/100ps
module light_sensor_adc_readout #(
  parameter int unsigned OSC_DIV = light_sensor_pkg::OSC_DIV
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port from the serial slave.
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  input  wire logic        mode_xfer_done,
  output logic [7:0]       reg_rdata_q,
  // Analog front end.
  input  wire logic        photo_pulse_pin,
  output light_sensor_pkg::front_end_t front_end_q,
  // Open-drain interrupt pin.
  output logic             irq_out_q,
  output logic             irq_oe_n_q
);

  light_sensor_pkg::cmd_mode_t cmd_mode_q;
  light_sensor_pkg::cmd_res_t  cmd_res_q;
  logic [15:0] result_q;
  logic [15:0] lower_limit_q;
  logic [15:0] upper_limit_q;
  logic [4:0]  persist_cnt_q;
  logic [4:0]  persist_need;
  logic [2:0]  photo_sync_q;
  logic        photo_level_q;
  logic        photo_event;
  logic        run;
  logic        conv_done;
  logic [15:0] conv_result;
  logic        outside;
  logic        flag_set;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Photodiode pulse pin crosses in through three flops.
  always_ff @(posedge clk) begin
    if (reset) begin
      photo_sync_q <= 3'h0;
    end else begin
      photo_sync_q <= {photo_sync_q[1:0], photo_pulse_pin};
    end
  end

  // A level only counts once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (reset) begin
      photo_level_q <= 1'b0;
    end else if (photo_sync_q[1] == photo_sync_q[2]) begin
      photo_level_q <= photo_sync_q[2];
    end
  end

  assign photo_event = photo_sync_q[1] && photo_sync_q[2] && !photo_level_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Reserved mode codes are treated like power-down so nothing runs on an undefined setting.
  assign run = (cmd_mode_q.mode == light_sensor_pkg::MODE_VISIBLE) ||
               (cmd_mode_q.mode == light_sensor_pkg::MODE_INFRARED);

  conversion_engine #(
    .OSC_DIV (OSC_DIV)
  ) u_engine (
    .clk         (clk),
    .reset       (reset),
    .run         (run),
    .resolution  (cmd_res_q.resolution),
    .photo_event (photo_event),
    .done_q      (conv_done),
    .result_q    (conv_result)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Mode register; the flag bit is owned by hardware.
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_mode_q.mode    <= light_sensor_pkg::MODE_POWER_DOWN;
      cmd_mode_q.zero    <= 2'h0;
      cmd_mode_q.persist <= light_sensor_pkg::PERSIST_1;
    end else if (reg_wr && reg_addr == light_sensor_pkg::ADDR_CMD_MODE) begin
      cmd_mode_q.mode    <= reg_wdata[7:5];
      cmd_mode_q.persist <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_res_q <= light_sensor_pkg::RST_CMD;
    end else if (reg_wr && reg_addr == light_sensor_pkg::ADDR_CMD_RES) begin
      cmd_res_q.zero       <= 4'h0;
      cmd_res_q.resolution <= reg_wdata[3:2];
      cmd_res_q.span       <= reg_wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Limits.
  always_ff @(posedge clk) begin
    if (reset) begin
      lower_limit_q <= {light_sensor_pkg::RST_LOWLIM, light_sensor_pkg::RST_LOWLIM};
    end else if (reg_wr && reg_addr == light_sensor_pkg::ADDR_LOWLIM_LO) begin
      lower_limit_q[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == light_sensor_pkg::ADDR_LOWLIM_HI) begin
      lower_limit_q[15:8] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      upper_limit_q <= {light_sensor_pkg::RST_UPLIM, light_sensor_pkg::RST_UPLIM};
    end else if (reg_wr && reg_addr == light_sensor_pkg::ADDR_UPLIM_LO) begin
      upper_limit_q[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == light_sensor_pkg::ADDR_UPLIM_HI) begin
      upper_limit_q[15:8] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Result is written as one word, so its two bytes never mix conversions; bus writes never
  // reach it.
  always_ff @(posedge clk) begin
    if (reset) begin
      result_q <= {light_sensor_pkg::RST_RESULT, light_sensor_pkg::RST_RESULT};
    end else if (conv_done) begin
      result_q <= conv_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Persistence counting of consecutive results outside the window.
  assign outside = (conv_result < lower_limit_q) || (conv_result > upper_limit_q);

  always_comb begin
    unique case (cmd_mode_q.persist)
      light_sensor_pkg::PERSIST_1: persist_need = light_sensor_pkg::PERSIST_CNT_1;
      light_sensor_pkg::PERSIST_4: persist_need = light_sensor_pkg::PERSIST_CNT_4;
      light_sensor_pkg::PERSIST_8: persist_need = light_sensor_pkg::PERSIST_CNT_8;
      default:                     persist_need = light_sensor_pkg::PERSIST_CNT_16;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset || !run) begin
      persist_cnt_q <= 5'h00;
    end else if (conv_done) begin
      if (!outside) begin
        persist_cnt_q <= 5'h00;
      end else if (persist_cnt_q < persist_need) begin
        persist_cnt_q <= persist_cnt_q + 5'h01;
      end
    end
  end

  assign flag_set = conv_done && outside && (persist_cnt_q + 5'h01 >= persist_need);

  // A new trigger in the same cycle as the clearing transfer keeps the flag set.
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_mode_q.flag <= 1'b0;
    end else if (flag_set) begin
      cmd_mode_q.flag <= 1'b1;
    end else if (mode_xfer_done) begin
      cmd_mode_q.flag <= 1'b0;
    end
  end

  // Pin follows the flag one cycle later; it is low-driven only, never driven high.
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_out_q  <= 1'b0;
      irq_oe_n_q <= 1'b1;
    end else begin
      irq_out_q  <= 1'b0;
      irq_oe_n_q <= !cmd_mode_q.flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Front-end controls.
  always_ff @(posedge clk) begin
    if (reset) begin
      front_end_q <= '0;
    end else begin
      front_end_q.powered  <= run;
      front_end_q.infrared <= (cmd_mode_q.mode == light_sensor_pkg::MODE_INFRARED);
      front_end_q.span     <= cmd_res_q.span;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Read data; unmapped addresses read zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        light_sensor_pkg::ADDR_CMD_MODE:  reg_rdata_q <= cmd_mode_q;
        light_sensor_pkg::ADDR_CMD_RES:   reg_rdata_q <= cmd_res_q;
        light_sensor_pkg::ADDR_RESULT_LO: reg_rdata_q <= result_q[7:0];
        light_sensor_pkg::ADDR_RESULT_HI: reg_rdata_q <= result_q[15:8];
        light_sensor_pkg::ADDR_LOWLIM_LO: reg_rdata_q <= lower_limit_q[7:0];
        light_sensor_pkg::ADDR_LOWLIM_HI: reg_rdata_q <= lower_limit_q[15:8];
        light_sensor_pkg::ADDR_UPLIM_LO:  reg_rdata_q <= upper_limit_q[7:0];
        light_sensor_pkg::ADDR_UPLIM_HI:  reg_rdata_q <= upper_limit_q[15:8];
        default:                          reg_rdata_q <= 8'h00;
      endcase
    end
  end

endmodule : light_sensor_adc_readout

// file: logic/light_sensor_pkg.sv
// Shared constants, register layout and field types for the light sensor readout.
// Assumes a 200 MHz system clock and a byte-wide register port from the serial slave.
package light_sensor_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] ADDR_CMD_MODE   = 8'h00;
  localparam logic [7:0] ADDR_CMD_RES    = 8'h01;
  localparam logic [7:0] ADDR_RESULT_LO  = 8'h02;
  localparam logic [7:0] ADDR_RESULT_HI  = 8'h03;
  localparam logic [7:0] ADDR_LOWLIM_LO  = 8'h04;
  localparam logic [7:0] ADDR_LOWLIM_HI  = 8'h05;
  localparam logic [7:0] ADDR_UPLIM_LO   = 8'h06;
  localparam logic [7:0] ADDR_UPLIM_HI   = 8'h07;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] RST_CMD         = 8'h00;
  localparam logic [7:0] RST_RESULT      = 8'h00;
  localparam logic [7:0] RST_LOWLIM      = 8'h00;
  localparam logic [7:0] RST_UPLIM       = 8'hff;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Field encodings.
  localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
  localparam logic [2:0] MODE_VISIBLE    = 3'h5;
  localparam logic [2:0] MODE_INFRARED   = 3'h6;
  localparam logic [1:0] RES_16          = 2'h0;
  localparam logic [1:0] RES_12          = 2'h1;
  localparam logic [1:0] RES_8           = 2'h2;
  localparam logic [1:0] RES_4           = 2'h3;
  localparam logic [1:0] PERSIST_1       = 2'h0;
  localparam logic [1:0] PERSIST_4       = 2'h1;
  localparam logic [1:0] PERSIST_8       = 2'h2;
  localparam logic [4:0] PERSIST_CNT_1   = 5'h01;
  localparam logic [4:0] PERSIST_CNT_4   = 5'h04;
  localparam logic [4:0] PERSIST_CNT_8   = 5'h08;
  localparam logic [4:0] PERSIST_CNT_16  = 5'h10;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int unsigned CLK_RATE_HZ    = 200_000_000;
  localparam int unsigned OSC_RATE_HZ    = 655_000;
  localparam int unsigned OSC_DIV        = CLK_RATE_HZ / OSC_RATE_HZ;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register fields.
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] zero;
    logic       flag;
    logic [1:0] persist;
  } cmd_mode_t;

  typedef struct packed {
    logic [3:0] zero;
    logic [1:0] resolution;
    logic [1:0] span;
  } cmd_res_t;

  typedef struct packed {
    logic       powered;
    logic       infrared;
    logic [1:0] span;
  } front_end_t;

  // Mask of valid result bits for a resolution code; also the last oscillator cycle index.
  function automatic logic [15:0] res_mask(input logic [1:0] res);
    unique case (res)
      RES_16:  res_mask = 16'hffff;
      RES_12:  res_mask = 16'h0fff;
      RES_8:   res_mask = 16'h00ff;
      default: res_mask = 16'h000f;
    endcase
  endfunction : res_mask

endpackage : light_sensor_pkg

// file: tb/host_model.sv
// Host side model: byte register transfers and interrupt acknowledges.
// Assumes every task is entered one unit after a rising edge of clk.
`timescale 1ns/100ps
module host_model (
  // Clock.
  input  wire logic       clk,
  // Register port.
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  output logic            mode_xfer_done,
  input  wire logic [7:0] reg_rdata_q
);
  initial begin
    {reg_addr, reg_wr, reg_wdata, reg_rd, mode_xfer_done} = '0;
  end
  task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
    @(posedge clk);
    #1;
  endtask : put
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, 1'b0, a, d);
  endtask : wr
  // Unused data is inverted so a stale value never looks valid.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(1'b0, 1'b1, a, ~reg_wdata);
    d = reg_rdata_q;
  endtask : rd
  task automatic idle();
    put(1'b0, 1'b0, reg_addr, ~reg_wdata);
  endtask : idle
  task automatic ack();
    mode_xfer_done = 1'b1;
    idle();
    mode_xfer_done = 1'b0;
  endtask : ack
endmodule : host_model

// file: tb/readout_chk.sv
// Port checker for the light sensor readout.
// Assumes it is bound into every readout instance and sees only its ports.
`timescale 1ns/100ps
module readout_chk #(
  parameter int unsigned OSC_DIV = 2
) (
  // Clock and reset.
  input logic                         clk,
  input logic                         reset,
  // Register port.
  input logic [7:0]                   reg_addr,
  input logic                         reg_wr,
  input logic [7:0]                   reg_wdata,
  input logic                         reg_rd,
  input logic                         mode_xfer_done,
  input logic [7:0]                   reg_rdata_q,
  // Front end and interrupt pin.
  input logic                         photo_pulse_pin,
  input light_sensor_pkg::front_end_t front_end_q,
  input logic                         irq_out_q,
  input logic                         irq_oe_n_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence mode_wr_s;
    reg_wr && reg_addr == 8'h00;
  endsequence
  sequence lim_wr_rd_s;
    reg_wr && reg_addr == 8'h04 ##1 reg_rd && !reg_wr && reg_addr == 8'h04;
  endsequence
  drain_low_a: assert property (irq_out_q == 1'b0)
    else $error("interrupt data not low");
  rst_state_a: assert property ($fell(reset) |-> irq_oe_n_q && front_end_q == '0
    && reg_rdata_q == 8'h00) else $error("bad state after reset");
  // The front end follows the registers one cycle later, so these look two edges on.
  power_sel_a: assert property (mode_wr_s |=> ##1 front_end_q.powered ==
    ($past(reg_wdata[7:5], 2) inside {3'h5, 3'h6})) else $error("power select wrong");
  ir_sel_a: assert property (mode_wr_s |=> ##1 front_end_q.infrared ==
    ($past(reg_wdata[7:5], 2) == 3'h6)) else $error("infrared select wrong");
  span_sel_a: assert property (reg_wr && reg_addr == 8'h01 |=> ##1
    front_end_q.span == $past(reg_wdata[1:0], 2)) else $error("span select wrong");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  unmapped_a: assert property (reg_rd && reg_addr > 8'h07 |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  // Armed only while stopped, since a new outside result wins over the acknowledge.
  ack_clear_a: assert property (mode_xfer_done && !front_end_q.powered
    |=> ##1 irq_oe_n_q) else $error("acknowledge did not release the pin");
  lim_back_a: assert property (lim_wr_rd_s |=> reg_rdata_q == $past(reg_wdata, 2))
    else $error("lower limit readback wrong");
endmodule : readout_chk
bind light_sensor_adc_readout readout_chk #(.OSC_DIV(OSC_DIV)) chk_u (.clk, .reset,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .mode_xfer_done, .reg_rdata_q,
  .photo_pulse_pin, .front_end_q, .irq_out_q, .irq_oe_n_q);

// file: tb/tb_top.sv
// Self-checking bench for the light sensor readout.
// Assumes the host model drives the register port and the bench drives light pulses.
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned DIV = 8;
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] span;
    logic [3:0] fe;
  } row_t;
  row_t rows [8] = '{9'h000, 9'h051, 9'h0a2, 9'h0f3, 9'h100, 9'h159, 9'h1ae, 9'h1f3};
  logic                         clk = 1'b0;
  logic                         reset = 1'b1;
  logic                         photo = 1'b0;
  logic                         photo_en = 1'b0;
  logic [7:0]                   addr;
  logic [7:0]                   wdata;
  logic [7:0]                   rdata;
  logic [7:0]                   got;
  logic                         wr;
  logic                         rd;
  logic                         done;
  logic                         irq_out_q;
  logic                         irq_oe_n_q;
  light_sensor_pkg::front_end_t fe;
  int                           mismatches = 0;
  int                           samples_checked = 0;
  light_sensor_adc_readout #(.OSC_DIV(DIV)) dut_u (.clk(clk), .reset(reset),
    .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .mode_xfer_done(done),
    .reg_rdata_q(rdata), .photo_pulse_pin(photo), .front_end_q(fe),
    .irq_out_q(irq_out_q), .irq_oe_n_q(irq_oe_n_q));
  host_model host_u (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
    .reg_rd(rd), .mode_xfer_done(done), .reg_rdata_q(rdata));
  always #2.5 clk = ~clk;
  // Pulses stay three cycles high and low, one more than the two-cycle shortest the front end accepts.
  always begin
    repeat (3) @(posedge clk);
    #1 photo = photo_en & ~photo;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : pause
  // Dense light saturates every window, so the result is the width's full count.
  task automatic conv(input logic [1:0] res, input int prev, input int len,
                      input logic [7:0] lo, input logic [7:0] hi);
    host_u.wr(8'h01, {4'h0, res, 2'h0});
    host_u.idle();
    pause(DIV * (prev + len) + 20);
    host_u.rd(8'h02, got);
    check(got, lo);
    host_u.rd(8'h03, got);
    check(got, hi);
    host_u.idle();
  endtask : conv
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #450_000;
    mismatches++;
    summarize();
  end
  initial begin
    pause(10);
    reset = 1'b0;
    host_u.idle();
    for (int a = 0; a < 9; a++) begin
      host_u.rd(a[7:0], got);
      check(got, (a == 6 || a == 7) ? 8'hff : 8'h00);
    end
    foreach (rows[i]) begin
      host_u.wr(8'h00, {rows[i].mode, 5'h00});
      host_u.wr(8'h01, {6'h00, rows[i].span});
      host_u.idle();
      check({4'h0, fe}, {4'h0, rows[i].fe});
    end
    host_u.wr(8'h04, 8'h5a);
    host_u.rd(8'h04, got);
    check(got, 8'h5a);
    host_u.wr(8'h07, 8'h3c);
    host_u.rd(8'h07, got);
    check(got, 8'h3c);
    host_u.wr(8'h02, 8'h33);
    host_u.rd(8'h02, got);
    check(got, 8'h00);
    host_u.wr(8'h04, 8'h00);
    host_u.wr(8'h07, 8'hff);
    photo_en = 1'b1;
    host_u.wr(8'h01, 8'h0c);
    host_u.wr(8'h00, 8'ha0);
    conv(2'h1, 16, 4096, 8'hff, 8'h0f);
    conv(2'h2, 4096, 256, 8'hff, 8'h00);
    conv(2'h3, 256, 16, 8'h0f, 8'h00);
    host_u.wr(8'h06, 8'h05);
    host_u.wr(8'h07, 8'h00);
    host_u.idle();
    pause(300);
    check({7'h0, irq_oe_n_q}, 8'h00);
    host_u.rd(8'h00, got);
    check(got, 8'ha4);
    host_u.wr(8'h00, 8'h00);
    host_u.idle();
    pause(4);
    host_u.ack();
    pause(3);
    check({7'h0, irq_oe_n_q}, 8'h01);
    host_u.wr(8'h00, 8'ha1);
    host_u.idle();
    pause(300);
    check({7'h0, irq_oe_n_q}, 8'h01);
    pause(400);
    check({7'h0, irq_oe_n_q}, 8'h00);
    photo_en = 1'b0;
    pause(300);
    host_u.rd(8'h02, got);
    check(got, 8'h00);
    host_u.ack();
    pause(300);
    check({7'h0, irq_oe_n_q}, 8'h01);
    check({7'h0, irq_out_q}, 8'h00);
    // Restart from power-down so each persistence count begins on a fresh window.
    photo_en = 1'b1;
    for (int p = 2; p < 4; p++) begin
      host_u.wr(8'h00, 8'h00);
      host_u.idle();
      host_u.ack();
      host_u.wr(8'h00, {6'h28, p[1:0]});
      host_u.idle();
      pause(DIV * 16 * (2 << p) - 61);
      check({7'h0, irq_oe_n_q}, 8'h01);
      pause(120);
      check({7'h0, irq_oe_n_q}, 8'h00);
    end
    summarize();
  end
endmodule : tb_top
